// ==== audio_clip_loader_player.sv ====
// Hex load record decoder feeding a serial flash writer, a clip directory
// store, and a playback engine that streams flash bytes into a duty register.
// Assumes the host character stream, flash writer and serial reader all run
// on core_clk; the serial reader shifts continuously while its run is high.
`timescale 1ns/10ps

// Summary of operation
// - Directory in 32-byte records; samples only in flash
// - Clip lookup scans only directory records
// - Separate erase per memory, never crossing
// - Addresses flash-relative; extended record sets upper bits
// - Accept 32-byte records and shorter ones
// - Line starting with colon is load record
// - Spaces inside records are dropped
// - Fields: count, address, type, data, checksum
// - Types 0 data, 1 end, 2 offset, 4 extended
// - Speak matches name, reads start, length, rate
// - Each sample byte written to duty register
// - Shift clock runs at eight times sample rate
// - Receive-available flag paces each new sample
// - Directory gives length, rate; wave header does if either is zero
// - Samples are 8-bit unsigned, typically 4 kHz
// - Sample rates 4000 to 16000 supported
module audio_clip_loader_player #(
	parameter int DIR_ENTRIES = 16,
	parameter int FLASH_AW = 24
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// Host character stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic rx_ready,
	output logic load_eof,
	output logic load_error,
	// Flash writer and erase
	output logic flash_wr_valid,
	output logic [FLASH_AW-1:0] flash_wr_addr,
	output logic [7:0] flash_wr_data,
	input wire logic flash_wr_ready,
	input wire logic flash_erase_req,
	output logic flash_erase,
	// Directory record writes and erase
	input wire logic dir_wr_valid,
	input wire logic [$clog2(DIR_ENTRIES)-1:0] dir_wr_index,
	input wire logic [clip_player_pkg::REC_BITS-1:0] dir_wr_record,
	input wire logic dir_erase_req,
	// Speak command
	input wire logic speak_req,
	input wire logic [clip_player_pkg::NAME_W-1:0] speak_name,
	output logic speak_busy,
	output logic speak_done,
	output logic speak_miss,
	// Serial flash reader
	output logic spi_run,
	output logic [FLASH_AW-1:0] spi_addr,
	output logic [clip_player_pkg::PERIOD_W-1:0] spi_period,
	input wire logic spi_rx_avail,
	input wire logic [7:0] spi_rx_byte,
	// Duty output
	output logic [7:0] pwm_duty
);

	localparam int IW = $clog2(DIR_ENTRIES);
	localparam int DW = clip_player_pkg::DIV_W;
	localparam int WW = clip_player_pkg::WORD_W;
	localparam int PERIOD_W_L = clip_player_pkg::PERIOD_W;

	typedef enum {P_IDLE, P_REC, P_SKIP, P_WRITE} parse_t;
	typedef enum {S_IDLE, S_SEARCH, S_HDR, S_DIV, S_PLAY} play_t;

	function automatic logic [4:0] hex_nibble(input logic [7:0] c);
		if (c >= "0" && c <= "9")
			hex_nibble = {1'b1, 4'(c - "0")};
		else if (c >= "A" && c <= "F")
			hex_nibble = {1'b1, 4'(c - "A" + 8'd10)};
		else if (c >= "a" && c <= "f")
			hex_nibble = {1'b1, 4'(c - "a" + 8'd10)};
		else
			hex_nibble = 5'h00;
	endfunction

	// ======================================================================
	// Load record decoder
	parse_t pstate_reg;
	logic have_hi_reg;
	logic [3:0] hi_nib_reg;
	logic [5:0] byte_idx_reg;
	logic [7:0] sum_reg;
	logic [7:0] count_reg;
	logic [15:0] rec_addr_reg;
	logic [7:0] type_reg;
	logic [7:0] payload [clip_player_pkg::MAX_PAYLOAD];
	logic [WW-1:0] base_reg;
	logic [5:0] wr_idx_reg;
	logic [4:0] nib;
	logic [7:0] rx_byte;
	logic is_eol;
	logic rec_ok;

	assign nib = hex_nibble(rx_char);
	assign rx_byte = {hi_nib_reg, nib[3:0]};
	assign is_eol = (rx_char == clip_player_pkg::CH_CR) ||
		(rx_char == clip_player_pkg::CH_LF);
	// A checksum that verifies makes the byte sum wrap to zero.
	assign rec_ok = !have_hi_reg && (sum_reg == 8'h00) &&
		(count_reg <= 8'(clip_player_pkg::MAX_PAYLOAD)) &&
		(byte_idx_reg == 6'(count_reg + 8'(clip_player_pkg::REC_OVERHEAD)));

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			pstate_reg <= P_IDLE;
			have_hi_reg <= 1'b0;
			hi_nib_reg <= 4'h0;
			byte_idx_reg <= 6'h00;
			sum_reg <= 8'h00;
			count_reg <= 8'h00;
			rec_addr_reg <= 16'h0000;
			type_reg <= 8'h00;
			base_reg <= 32'h0000_0000;
			wr_idx_reg <= 6'h00;
			flash_wr_valid <= 1'b0;
			flash_wr_addr <= '0;
			flash_wr_data <= 8'h00;
			load_eof <= 1'b0;
			load_error <= 1'b0;
			rx_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			load_eof <= 1'b0;
			load_error <= 1'b0;
			rx_ready <= (pstate_reg != P_WRITE);
			unique case (pstate_reg)
				P_IDLE:
					if (rx_valid && rx_ready)
					begin
						have_hi_reg <= 1'b0;
						byte_idx_reg <= 6'h00;
						sum_reg <= 8'h00;
						if (rx_char == clip_player_pkg::CH_COLON)
							pstate_reg <= P_REC;
						else if (!is_eol)
							pstate_reg <= P_SKIP;
					end
				P_SKIP:
					if (rx_valid && is_eol)
						pstate_reg <= P_IDLE;
				P_REC:
					if (rx_valid)
					begin
						if (rx_char == clip_player_pkg::CH_SPACE)
							pstate_reg <= P_REC;
						else if (is_eol && !rec_ok)
						begin
							load_error <= 1'b1;
							pstate_reg <= P_IDLE;
						end
						else if (is_eol)
						begin
							pstate_reg <= P_IDLE;
							unique case (type_reg)
								clip_player_pkg::REC_DATA:
								begin
									wr_idx_reg <= 6'h00;
									pstate_reg <= P_WRITE;
								end
								clip_player_pkg::REC_EOF:
									load_eof <= 1'b1;
								clip_player_pkg::REC_SEGMENT:
									base_reg <= WW'({payload[0], payload[1]})
										<< clip_player_pkg::SEG_SHIFT;
								clip_player_pkg::REC_EXTENDED:
									base_reg <= WW'({payload[0], payload[1]})
										<< clip_player_pkg::EXT_SHIFT;
								default:
									load_error <= 1'b1;
							endcase
						end
						else if (!nib[4])
						begin
							load_error <= 1'b1;
							pstate_reg <= P_SKIP;
						end
						else if (!have_hi_reg)
						begin
							hi_nib_reg <= nib[3:0];
							have_hi_reg <= 1'b1;
						end
						// Guard the payload store against overlong records.
						else if (byte_idx_reg >= 6'(clip_player_pkg::MAX_PAYLOAD +
							clip_player_pkg::REC_OVERHEAD))
						begin
							load_error <= 1'b1;
							pstate_reg <= P_SKIP;
						end
						else
						begin
							have_hi_reg <= 1'b0;
							sum_reg <= sum_reg + rx_byte;
							byte_idx_reg <= byte_idx_reg + 6'h01;
							unique case (int'(byte_idx_reg))
								clip_player_pkg::IDX_COUNT: count_reg <= rx_byte;
								clip_player_pkg::IDX_ADDR_HI:
									rec_addr_reg[15:8] <= rx_byte;
								clip_player_pkg::IDX_ADDR_LO:
									rec_addr_reg[7:0] <= rx_byte;
								clip_player_pkg::IDX_TYPE: type_reg <= rx_byte;
								default:
									if (byte_idx_reg < 6'(count_reg +
										8'(clip_player_pkg::IDX_DATA)))
										payload[5'(byte_idx_reg - 6'(
											clip_player_pkg::IDX_DATA))] <= rx_byte;
							endcase
						end
					end
				P_WRITE:
					if (!flash_wr_valid || flash_wr_ready)
					begin
						// Any count up to the full payload is streamed out.
						if (wr_idx_reg < 6'(count_reg))
						begin
							flash_wr_valid <= 1'b1;
							flash_wr_addr <= FLASH_AW'(base_reg +
								WW'(rec_addr_reg) + WW'(wr_idx_reg));
							flash_wr_data <= payload[5'(wr_idx_reg)];
							wr_idx_reg <= wr_idx_reg + 6'h01;
						end
						else
						begin
							flash_wr_valid <= 1'b0;
							pstate_reg <= P_IDLE;
						end
					end
			endcase
		end
	end

	// ======================================================================
	// Directory store and erase commands
	logic [clip_player_pkg::REC_BITS-1:0] dir_mem [DIR_ENTRIES];
	logic [DIR_ENTRIES-1:0] dir_valid_reg;

	always_ff @(posedge core_clk)
	begin
		if (clk_en && dir_wr_valid)
			dir_mem[dir_wr_index] <= dir_wr_record;
	end

	// Each erase touches only its own memory.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			dir_valid_reg <= '0;
			flash_erase <= 1'b0;
		end
		else if (clk_en)
		begin
			flash_erase <= flash_erase_req;
			if (dir_erase_req)
				dir_valid_reg <= '0;
			else if (dir_wr_valid)
				dir_valid_reg[dir_wr_index] <= 1'b1;
		end
	end

	// ======================================================================
	// Playback engine
	play_t sstate_reg;
	logic [IW-1:0] sidx_reg;
	logic [clip_player_pkg::NAME_W-1:0] name_reg;
	logic [WW-1:0] start_reg;
	logic [WW-1:0] len_reg;
	logic [WW-1:0] rate_reg;
	logic hdr_mode_reg;
	logic [5:0] hdr_idx_reg;
	logic [DW-1:0] dividend_reg;
	logic [DW-1:0] rem_reg;
	logic [DW-1:0] divisor_reg;
	logic [PERIOD_W_L-1:0] quot_reg;
	logic [4:0] div_step_reg;
	logic [clip_player_pkg::REC_BITS-1:0] ent;
	logic [DW-1:0] rem_shift;
	logic [WW-1:0] rate_clamped;

	assign ent = dir_mem[sidx_reg];
	assign rem_shift = {rem_reg[DW-2:0], dividend_reg[DW-1]};
	// Out-of-range rates are pinned to the supported band.
	assign rate_clamped =
		(rate_reg < WW'(clip_player_pkg::RATE_MIN)) ?
			WW'(clip_player_pkg::RATE_MIN) :
		(rate_reg > WW'(clip_player_pkg::RATE_MAX)) ?
			WW'(clip_player_pkg::RATE_MAX) : rate_reg;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			sstate_reg <= S_IDLE;
			sidx_reg <= '0;
			name_reg <= '0;
			start_reg <= 32'h0000_0000;
			len_reg <= 32'h0000_0000;
			rate_reg <= 32'h0000_0000;
			hdr_mode_reg <= 1'b0;
			hdr_idx_reg <= 6'h00;
			dividend_reg <= '0;
			rem_reg <= '0;
			divisor_reg <= '0;
			quot_reg <= '0;
			div_step_reg <= 5'h00;
			speak_busy <= 1'b0;
			speak_done <= 1'b0;
			speak_miss <= 1'b0;
			spi_run <= 1'b0;
			spi_addr <= '0;
			spi_period <= '0;
			pwm_duty <= 8'h00;
		end
		else if (clk_en)
		begin
			speak_done <= 1'b0;
			speak_miss <= 1'b0;
			unique case (sstate_reg)
				S_IDLE:
					if (speak_req)
					begin
						name_reg <= speak_name;
						sidx_reg <= '0;
						speak_busy <= 1'b1;
						sstate_reg <= S_SEARCH;
					end
				S_SEARCH:
					// Only directory records are scanned, one per cycle.
					if (dir_valid_reg[sidx_reg] && ent[clip_player_pkg::NAME_LSB
						+: clip_player_pkg::NAME_W] == name_reg)
					begin
						start_reg <= ent[clip_player_pkg::START_LSB +: WW];
						len_reg <= ent[clip_player_pkg::LEN_LSB +: WW];
						rate_reg <= WW'(ent[clip_player_pkg::RATE_LSB +:
							clip_player_pkg::RATE_W]);
						// A zero length or rate means the header supplies both.
						hdr_mode_reg <= 1'b0;
						if (ent[clip_player_pkg::LEN_LSB +: WW] == 32'h0000_0000 ||
							ent[clip_player_pkg::RATE_LSB +:
							clip_player_pkg::RATE_W] == 16'h0000)
						begin
							hdr_mode_reg <= 1'b1;
							hdr_idx_reg <= 6'h00;
							spi_addr <= FLASH_AW'(ent[clip_player_pkg::START_LSB
								+: WW]);
							spi_period <= PERIOD_W_L'(clip_player_pkg::HDR_PERIOD);
							spi_run <= 1'b1;
							sstate_reg <= S_HDR;
						end
						else
						begin
							div_step_reg <= 5'h00;
							sstate_reg <= S_DIV;
						end
					end
					else if (sidx_reg == IW'(DIR_ENTRIES - 1))
					begin
						speak_miss <= 1'b1;
						speak_done <= 1'b1;
						speak_busy <= 1'b0;
						sstate_reg <= S_IDLE;
					end
					else
						sidx_reg <= sidx_reg + IW'(1);
				S_HDR:
					if (spi_rx_avail)
					begin
						hdr_idx_reg <= hdr_idx_reg + 6'h01;
						if (hdr_idx_reg == 6'h00 &&
							spi_rx_byte != clip_player_pkg::RIFF_TAG)
						begin
							spi_run <= 1'b0;
							speak_miss <= 1'b1;
							speak_done <= 1'b1;
							speak_busy <= 1'b0;
							sstate_reg <= S_IDLE;
						end
						// Header words are little endian.
						if (hdr_idx_reg >= 6'(clip_player_pkg::HDR_RATE_POS) &&
							hdr_idx_reg < 6'(clip_player_pkg::HDR_RATE_POS + 4))
							rate_reg <= {spi_rx_byte, rate_reg[WW-1:8]};
						if (hdr_idx_reg >= 6'(clip_player_pkg::HDR_LEN_POS) &&
							hdr_idx_reg < 6'(clip_player_pkg::HDR_LEN_POS + 4))
							len_reg <= {spi_rx_byte, len_reg[WW-1:8]};
						if (hdr_idx_reg ==
							6'(clip_player_pkg::WAV_HDR_BYTES - 1))
						begin
							spi_run <= 1'b0;
							div_step_reg <= 5'h00;
							sstate_reg <= S_DIV;
						end
					end
				S_DIV:
					// Shift period in core cycles is the clock over eight
					// times the rate, by restoring division.
					if (div_step_reg == 5'h00)
					begin
						dividend_reg <= DW'(clip_player_pkg::CLK_HZ);
						divisor_reg <= DW'(rate_clamped *
							WW'(clip_player_pkg::BITS_PER_SAMPLE));
						rem_reg <= '0;
						quot_reg <= '0;
						div_step_reg <= 5'h01;
					end
					else if (div_step_reg <= 5'(DW))
					begin
						dividend_reg <= {dividend_reg[DW-2:0], 1'b0};
						div_step_reg <= div_step_reg + 5'h01;
						if (rem_shift >= divisor_reg)
						begin
							rem_reg <= rem_shift - divisor_reg;
							quot_reg <= {quot_reg[PERIOD_W_L-2:0], 1'b1};
						end
						else
						begin
							rem_reg <= rem_shift;
							quot_reg <= {quot_reg[PERIOD_W_L-2:0], 1'b0};
						end
					end
					else if (len_reg == 32'h0000_0000)
					begin
						speak_done <= 1'b1;
						speak_busy <= 1'b0;
						sstate_reg <= S_IDLE;
					end
					else
					begin
						spi_period <= quot_reg;
						spi_addr <= FLASH_AW'(start_reg + (hdr_mode_reg ?
							WW'(clip_player_pkg::WAV_HDR_BYTES) : WW'(0)));
						spi_run <= 1'b1;
						sstate_reg <= S_PLAY;
					end
				S_PLAY:
					// Only a completed received byte advances the stream.
					if (spi_rx_avail)
					begin
						pwm_duty <= spi_rx_byte;
						len_reg <= len_reg - 32'h0000_0001;
						if (len_reg == 32'h0000_0001)
						begin
							spi_run <= 1'b0;
							speak_done <= 1'b1;
							speak_busy <= 1'b0;
							sstate_reg <= S_IDLE;
						end
					end
			endcase
		end
	end

endmodule // audio_clip_loader_player

// ==== clip_player_pkg.sv ====
// Constants shared by the clip loader and player: characters, record
// types, directory record layout, wave header offsets and pacing figures.
// Assumes a 100 MHz core clock and byte-wide serial flash and host links.
package clip_player_pkg;

	// ======================================================================
	// Host line characters and load record layout
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam int MAX_PAYLOAD = 32;
	localparam int REC_OVERHEAD = 5;
	localparam int IDX_COUNT = 0;
	localparam int IDX_ADDR_HI = 1;
	localparam int IDX_ADDR_LO = 2;
	localparam int IDX_TYPE = 3;
	localparam int IDX_DATA = 4;
	localparam logic [7:0] REC_DATA = 8'h00;
	localparam logic [7:0] REC_EOF = 8'h01;
	localparam logic [7:0] REC_SEGMENT = 8'h02;
	localparam logic [7:0] REC_EXTENDED = 8'h04;
	localparam int SEG_SHIFT = 4;
	localparam int EXT_SHIFT = 16;

	// ======================================================================
	// Directory record: one 32-byte record per clip
	localparam int REC_BYTES = 32;
	localparam int REC_BITS = REC_BYTES * 8;
	localparam int NAME_LSB = 0;
	localparam int NAME_W = 128;
	localparam int START_LSB = 128;
	localparam int LEN_LSB = 160;
	localparam int RATE_LSB = 192;
	localparam int WORD_W = 32;
	localparam int RATE_W = 16;

	// ======================================================================
	// Wave header and sample pacing
	localparam logic [7:0] RIFF_TAG = 8'h52;
	localparam int WAV_HDR_BYTES = 44;
	localparam int HDR_RATE_POS = 24;
	localparam int HDR_LEN_POS = 40;
	localparam int BITS_PER_SAMPLE = 8;
	localparam int RATE_MIN = 4000;
	localparam int RATE_MAX = 16000;
	localparam int RATE_DEFAULT = 4000;
	localparam int CLK_HZ = 100_000_000;
	localparam int PERIOD_W = 16;
	localparam int DIV_W = 27;
	localparam int HDR_PERIOD = CLK_HZ / (BITS_PER_SAMPLE * RATE_DEFAULT);

endpackage

// ==== clip_player_props.sv ====
// Concurrent checks on the clip loader and player top-level ports.
// Assumes one core_clk domain with synchronous active-low rstn.
`timescale 1ns/10ps

module clip_player_props #(
	parameter int DIR_ENTRIES = 16,
	parameter int FLASH_AW = 24
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Loader and erase
	input wire logic rx_ready,
	input wire logic load_error,
	input wire logic flash_wr_valid,
	input wire logic [FLASH_AW-1:0] flash_wr_addr,
	input wire logic [7:0] flash_wr_data,
	input wire logic flash_wr_ready,
	input wire logic flash_erase_req,
	input wire logic flash_erase,
	input wire logic dir_erase_req,
	// Speak and playback
	input wire logic speak_req,
	input wire logic speak_busy,
	input wire logic speak_done,
	input wire logic speak_miss,
	input wire logic spi_run,
	input wire logic [FLASH_AW-1:0] spi_addr,
	input wire logic [clip_player_pkg::PERIOD_W-1:0] spi_period,
	input wire logic spi_rx_avail,
	input wire logic [7:0] pwm_duty
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// ======================================================================
	// Sequences
	sequence s_wr_stall;
		flash_wr_valid && !flash_wr_ready;
	endsequence
	sequence s_wr_held;
		flash_wr_valid && $stable(flash_wr_addr) && $stable(flash_wr_data);
	endsequence
	sequence s_spk_taken;
		speak_req && !speak_busy;
	endsequence

	// ======================================================================
	// Assertions
	a_erase_flash_pulse: assert property (flash_erase_req |=> flash_erase)
		else $error("flash erase pulse missing");
	a_dir_erase_isolated: assert property (dir_erase_req && !flash_erase_req |=> !flash_erase)
		else $error("directory erase touched flash");
	a_wr_held_stall: assert property (s_wr_stall |=> s_wr_held)
		else $error("flash write dropped while stalled");
	a_bad_rec_nowrite: assert property (load_error |-> !flash_wr_valid)
		else $error("flash write beside load error");
	a_ready_low_write: assert property (flash_wr_valid && $past(flash_wr_valid) |-> !rx_ready)
		else $error("host ready while flash busy");
	a_speak_busy_next: assert property (s_spk_taken |=> speak_busy)
		else $error("speak request not taken");
	a_miss_with_done: assert property (speak_miss |-> speak_done)
		else $error("miss without done");
	a_done_after_busy: assert property (speak_done |-> $past(speak_busy))
		else $error("done without a search");
	a_run_addr_steady: assert property (spi_run && $past(spi_run) |-> $stable(spi_addr) && $stable(spi_period))
		else $error("serial setup changed mid run");
	a_period_in_range: assert property (spi_run |-> spi_period inside {[16'd781:16'd3125]})
		else $error("shift period out of range");
	a_duty_from_sample: assert property ($changed(pwm_duty) |-> $past(spi_rx_avail) || $past(spi_rx_avail, 2))
		else $error("duty changed without a sample");
endmodule // clip_player_props

bind audio_clip_loader_player clip_player_props #(.DIR_ENTRIES(DIR_ENTRIES),
	.FLASH_AW(FLASH_AW)) clip_player_props_i (.core_clk(core_clk),
	.rstn(rstn), .rx_ready(rx_ready), .load_error(load_error),
	.flash_wr_valid(flash_wr_valid), .flash_wr_addr(flash_wr_addr),
	.flash_wr_data(flash_wr_data), .flash_wr_ready(flash_wr_ready),
	.flash_erase_req(flash_erase_req), .flash_erase(flash_erase),
	.dir_erase_req(dir_erase_req), .speak_req(speak_req),
	.speak_busy(speak_busy), .speak_done(speak_done), .speak_miss(speak_miss),
	.spi_run(spi_run), .spi_addr(spi_addr), .spi_period(spi_period),
	.spi_rx_avail(spi_rx_avail), .pwm_duty(pwm_duty));

// ==== hex_host_model.sv ====
// Host loader model: turns a byte list into one hex load record line.
// Assumes the caller fills dat before each send; waits for rx_ready first.
`timescale 1ns/10ps

module hex_host_model (
	// Clock and flow control
	input wire logic core_clk,
	input wire logic rx_ready,
	// Character stream
	output logic rx_valid,
	output logic [7:0] rx_char
);
	logic [7:0] dat [32];
	logic [7:0] q [$];
	int to_err = 0;

	initial
	begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
	end

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'd10) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	task automatic put(input logic [7:0] b, input logic sp);
		q.push_back(hx(b[7:4]));
		q.push_back(hx(b[3:0]));
		if (sp)
			q.push_back(clip_player_pkg::CH_SPACE);
	endtask

	// The payload never exceeds the 32-entry list, so lines stay short.
	task automatic send_rec(input logic [7:0] typ, input logic [15:0] adr,
		input int n, input logic bad, input logic colon, input logic sp);
		logic [7:0] sum;
		int k;
		q = {};
		if (colon)
			q.push_back(clip_player_pkg::CH_COLON);
		sum = 8'(n) + adr[15:8] + adr[7:0] + typ;
		put(8'(n), sp);
		put(adr[15:8], 1'b0);
		put(adr[7:0], sp);
		put(typ, sp);
		for (int i = 0; i < n; i++)
		begin
			put(dat[i], sp);
			sum += dat[i];
		end
		put((8'h00 - sum) ^ {7'h00, bad}, 1'b0);
		q.push_back(clip_player_pkg::CH_LF);
		k = 0;
		@(negedge core_clk);
		while (rx_ready !== 1'b1 && k < 500)
		begin
			@(negedge core_clk);
			k++;
		end
		if (rx_ready !== 1'b1)
			to_err++;
		foreach (q[i])
		begin
			rx_valid = 1'b1;
			rx_char = q[i];
			@(negedge core_clk);
		end
		rx_valid = 1'b0;
		rx_char = ~rx_char;
	endtask
endmodule // hex_host_model

// ==== audio_clip_loader_player_tb.sv ====
// Self-checking bench for the clip loader and player.
// Assumes the bound checker; serial reader and flash sink are modelled here.
`timescale 1ns/10ps

module audio_clip_loader_player_tb;
	localparam int BYTE_GAP = 40;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic rx_valid, rx_ready, load_eof, load_error, flash_wr_valid;
	logic flash_erase, speak_busy, speak_done, speak_miss, spi_run;
	logic [7:0] rx_char, flash_wr_data, pwm_duty;
	logic [23:0] flash_wr_addr, spi_addr, got_adr;
	logic [15:0] spi_period, got_per;
	logic flash_wr_ready = 1'b0;
	logic flash_erase_req = 1'b0;
	logic dir_wr_valid = 1'b0;
	logic [3:0] dir_wr_index = 4'h0;
	logic [255:0] dir_wr_record = '0;
	logic dir_erase_req = 1'b0;
	logic speak_req = 1'b0;
	logic [127:0] speak_name = '0;
	logic spi_rx_avail = 1'b0;
	logic [7:0] spi_rx_byte = 8'h00;
	logic [23:0] ofs = '0;
	logic exp_on = 1'b0;
	logic run_seen = 1'b0;
	logic av1 = 1'b0;
	logic av2 = 1'b0;
	logic [31:0] exp_wr [$];
	logic [7:0] exp_duty [$];
	int err_total = 0;
	int n_compared = 0;
	int gap = 0;
	int eof_n = 0;
	int err_n = 0;
	int fe_n = 0;
	int rts [5] = '{4000, 8000, 16000, 20000, 2000};
	int pers [5] = '{3125, 1562, 781, 781, 3125};

	always #5 core_clk = ~core_clk;

	audio_clip_loader_player #(.DIR_ENTRIES(16), .FLASH_AW(24))
	audio_clip_loader_player_i (.core_clk(core_clk), .rstn(rstn),
		.clk_en(clk_en), .rx_valid(rx_valid), .rx_char(rx_char),
		.rx_ready(rx_ready), .load_eof(load_eof), .load_error(load_error),
		.flash_wr_valid(flash_wr_valid), .flash_wr_addr(flash_wr_addr),
		.flash_wr_data(flash_wr_data), .flash_wr_ready(flash_wr_ready),
		.flash_erase_req(flash_erase_req), .flash_erase(flash_erase),
		.dir_wr_valid(dir_wr_valid), .dir_wr_index(dir_wr_index),
		.dir_wr_record(dir_wr_record), .dir_erase_req(dir_erase_req),
		.speak_req(speak_req), .speak_name(speak_name),
		.speak_busy(speak_busy), .speak_done(speak_done),
		.speak_miss(speak_miss), .spi_run(spi_run), .spi_addr(spi_addr),
		.spi_period(spi_period), .spi_rx_avail(spi_rx_avail),
		.spi_rx_byte(spi_rx_byte), .pwm_duty(pwm_duty));

	hex_host_model hex_host_model_i (.core_clk(core_clk), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_char(rx_char));

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_compared++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic results();
		err_total += hex_host_model_i.to_err;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ======================================================================
	// Far-side models and result watchers
	// Bytes come every BYTE_GAP + 1 cycles instead of eight shift periods, which
	// keeps runs short; the programmed period itself is compared directly.
	always @(negedge core_clk)
	begin
		flash_wr_ready <= ($urandom % 3) != 0;
		if (spi_run !== 1'b1)
		begin
			gap <= 0;
			ofs <= '0;
			spi_rx_avail <= 1'b0;
			spi_rx_byte <= ~spi_rx_byte;
		end
		else if (gap == BYTE_GAP)
		begin
			gap <= 0;
			ofs <= ofs + 24'd1;
			spi_rx_avail <= 1'b1;
			spi_rx_byte <= spi_addr[7:0] ^ ofs[7:0] ^ 8'h5A;
			if (exp_on)
				exp_duty.push_back(spi_addr[7:0] ^ ofs[7:0] ^ 8'h5A);
		end
		else
		begin
			gap <= gap + 1;
			spi_rx_avail <= 1'b0;
		end
	end

	always @(posedge core_clk)
	begin
		if (load_eof === 1'b1)
			eof_n++;
		if (load_error === 1'b1)
			err_n++;
		if (flash_erase === 1'b1)
			fe_n++;
		if (spi_run === 1'b1 && run_seen !== 1'b1)
		begin
			run_seen <= 1'b1;
			got_per <= spi_period;
			got_adr <= spi_addr;
		end
		if (flash_wr_valid === 1'b1 && flash_wr_ready === 1'b1)
		begin
			if (exp_wr.size() == 0)
				check("flash_wr extra", 0, 1);
			else
				check("flash_wr", exp_wr.pop_front(), {flash_wr_addr, flash_wr_data});
		end
		av1 <= spi_rx_avail && exp_on;
		av2 <= av1;
		if (av2 && exp_duty.size() > 0)
			check("pwm_duty", 32'(exp_duty.pop_front()), 32'(pwm_duty));
	end

	// ======================================================================
	// Stimulus tasks
	task automatic drain();
		int k;
		k = 0;
		while (exp_wr.size() != 0 && k < 2000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (exp_wr.size() != 0)
		begin
			check("flash drain", 0, 1);
			results();
		end
	endtask

	task automatic rec(input logic [7:0] typ, input logic [15:0] adr,
		input int n, input logic bad, input logic colon, input logic sp,
		input logic [23:0] b);
		if (b != 0)
			for (int i = 0; i < n; i++)
				exp_wr.push_back({b + 24'(i), hex_host_model_i.dat[i]});
		hex_host_model_i.send_rec(typ, adr, n, bad, colon, sp);
		if (hex_host_model_i.to_err != 0)
			results();
		drain();
	endtask

	task automatic dir_wr(input logic [3:0] ix, input logic [127:0] nm,
		input logic [31:0] st, input logic [31:0] ln, input logic [15:0] rt);
		@(negedge core_clk);
		dir_wr_valid = 1'b1;
		dir_wr_index = ix;
		dir_wr_record = {48'h0, rt, ln, st, nm};
		@(negedge core_clk);
		dir_wr_valid = 1'b0;
	endtask

	task automatic speak(input logic [127:0] nm, input logic [15:0] per,
		input logic miss, input logic play, input logic [23:0] adr);
		int k;
		exp_on = play;
		run_seen = 1'b0;
		@(negedge core_clk);
		speak_req = 1'b1;
		speak_name = nm;
		@(negedge core_clk);
		speak_req = 1'b0;
		k = 0;
		while (speak_done !== 1'b1 && k < 5000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (speak_done !== 1'b1)
		begin
			check("speak_done", 1, 0);
			results();
		end
		check("speak_miss", 32'(miss), 32'(speak_miss));
		if (per != 0)
		begin
			check("spi_period", 32'(per), 32'(got_per));
			check("spi_addr", 32'(adr), 32'(got_adr));
		end
		else
			check("spi_run seen", 0, 32'(run_seen));
		repeat (3) @(negedge core_clk);
		check("samples left", 0, 32'(exp_duty.size()));
		exp_on = 1'b0;
	endtask

	// ======================================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hd2d9));
		repeat (2) @(negedge core_clk);
		rstn = 1'b1;
		check("pwm_duty reset", 0, 32'(pwm_duty));
		hex_host_model_i.dat[0] = 8'h00;
		hex_host_model_i.dat[1] = 8'h01;
		rec(clip_player_pkg::REC_EXTENDED, 16'h0000, 2, 0, 1, 0, 0);
		for (int i = 0; i < 32; i++)
			hex_host_model_i.dat[i] = 8'($urandom);
		rec(clip_player_pkg::REC_DATA, 16'h0020, 32, 0, 1, 1, 24'h010020);
		rec(clip_player_pkg::REC_DATA, 16'h00F0, 3, 0, 1, 0, 24'h0100F0);
		hex_host_model_i.dat[0] = 8'h12;
		hex_host_model_i.dat[1] = 8'h34;
		rec(clip_player_pkg::REC_SEGMENT, 16'h0000, 2, 0, 1, 0, 0);
		hex_host_model_i.dat[0] = 8'hA5;
		rec(clip_player_pkg::REC_DATA, 16'h0005, 1, 0, 1, 1, 24'h012345);
		rec(clip_player_pkg::REC_DATA, 16'h0000, 4, 1, 1, 0, 0);
		rec(clip_player_pkg::REC_DATA, 16'h0000, 1, 0, 0, 0, 0);
		rec(clip_player_pkg::REC_EOF, 16'h0000, 0, 0, 1, 0, 0);
		repeat (4) @(negedge core_clk);
		check("load_eof count", 1, 32'(eof_n));
		check("load_error count", 1, 32'(err_n));
		@(negedge core_clk);
		flash_erase_req = 1'b1;
		@(negedge core_clk);
		flash_erase_req = 1'b0;
		dir_wr(4'h2, "CLIPA", 32'h100, 32'd4, 16'd16000);
		speak("CLIPA", 16'd781, 0, 1, 24'h000100);
		for (int i = 0; i < 5; i++)
		begin
			dir_wr(4'h5, "RATE", 32'h300, 32'd1, 16'(rts[i]));
			speak("RATE", 16'(pers[i]), 0, 1, 24'h000300);
		end
		dir_wr(4'h9, "HDR", 32'h200, 32'd0, 16'd8000);
		speak("HDR", 16'd3125, 1, 0, 24'h000200);
		clk_en = 1'b0;
		dir_wr(4'h3, "NONE", 32'h0, 32'd1, 16'd4000);
		clk_en = 1'b1;
		speak("NONE", 16'd0, 1, 0, 24'h0);
		@(negedge core_clk);
		dir_erase_req = 1'b1;
		@(negedge core_clk);
		dir_erase_req = 1'b0;
		speak("CLIPA", 16'd0, 1, 0, 24'h0);
		check("flash_erase count", 1, 32'(fe_n));
		results();
	end
endmodule // audio_clip_loader_player_tb
